// File: verilog/ucp_pkg.sv
// Constants and carrier types for the serial command port
// How it works
// - Both serial lines sit high whenever no character is in flight.
// - Each frame carries eight data bits, no parity and one stop bit.
// - After the data the sender holds the line high for at least one full bit time.
// - Each end times bits from its own clock, and both use the same bit rate.
// - Without reconfiguration the port runs at 9600 bit/s.
// - Low on the line is a zero bit and high is a one bit.
// - The receive pin is only an input and replies go out only on the transmit pin.
// - Serial commands are processed only while the serial/I2C/USB control mode is selected.
// - With the timeout enabled, a lapse in qualifying commands raises an error and stops the motor.
// - While an error stops the motor the red indicator is lit.
// - Compact-format commands carry no device number, so every device obeys them.
// - The error output is low normally and high while an error stops the motor.
package ucp_pkg;
   localparam int unsigned CLK_HZ        = 50_000_000;
   localparam int unsigned BAUD_DEFAULT  = 9600;
   localparam int unsigned OVERSAMPLE    = 16;
   localparam logic [15:0] OS_DIV        = 16'(CLK_HZ / (BAUD_DEFAULT * OVERSAMPLE));
   localparam logic [3:0]  OS_MID        = 4'h7;
   localparam logic [3:0]  OS_LAST       = 4'hf;
   localparam logic [2:0]  BIT_LAST      = 3'h7;
   localparam int unsigned TIMEOUT_MS    = 1000;
   localparam int unsigned TIMEOUT_CYC   = CLK_HZ / 1000 * TIMEOUT_MS;
   localparam int unsigned FIFO_DEPTH    = 8;
   localparam int unsigned DATA_W        = 8;
   localparam logic        LINE_IDLE     = 1'b1;
   localparam logic        START_LVL     = 1'b0;
   localparam logic [1:0]  MODE_SERIAL   = 2'h0;

   typedef enum logic [1:0] {
      UCP_IDLE  = 2'b00,
      UCP_START = 2'b01,
      UCP_DATA  = 2'b10,
      UCP_STOP  = 2'b11
   } ucp_state_e;

   typedef struct packed {
      logic [7:0] data;
   } ucp_byte_s;
endpackage

// File: verilog/ucp_fifo.sv
// Small flip-flop FIFO with valid/ready on both sides
`timescale 1ns/10ps
module ucp_fifo #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 8
) (
   input  wire logic             clock,
   input  wire logic             arst_n,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic [WIDTH-1:0]      out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int unsigned AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0]    wptr_r;
   logic [AW-1:0]    rptr_r;
   logic [AW:0]      count_r;
   logic             push;
   logic             pop;

   assign in_ready  = (count_r != (AW+1)'(DEPTH));
   assign out_valid = (count_r != '0);
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign out_data  = mem_r[rptr_r];

   always_ff @(posedge clock)
   begin
      if (push)
      begin
         mem_r[wptr_r] <= in_data;
      end
   end

   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         wptr_r  <= '0;
         rptr_r  <= '0;
         count_r <= '0;
      end
      else
      begin
         if (push)
         begin
            wptr_r <= (wptr_r == AW'(DEPTH-1)) ? '0 : wptr_r + 1'b1;
         end
         if (pop)
         begin
            rptr_r <= (rptr_r == AW'(DEPTH-1)) ? '0 : rptr_r + 1'b1;
         end
         count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

// File: verilog/ucp_port.sv
// Serial command port: 8-N-1 receiver, transmitter, receive FIFO, command timeout
`timescale 1ns/10ps
module ucp_port #(
   parameter int unsigned TIMEOUT_CYCLES = ucp_pkg::TIMEOUT_CYC
) (
   input  wire logic             clock,
   input  wire logic             arst_n,
   input  wire logic             rx_pin,
   output logic                  tx_pin,
   input  wire logic [1:0]       control_mode,
   input  wire logic             timeout_enable,
   input  wire logic             timeout_kick,
   input  wire logic             other_error,
   output ucp_pkg::ucp_byte_s    cmd_byte,
   output logic                  cmd_valid,
   input  wire logic             cmd_ready,
   output logic                  frame_error,
   input  ucp_pkg::ucp_byte_s    reply_byte,
   input  wire logic             reply_valid,
   output logic                  reply_ready,
   output logic                  timeout_error,
   output logic                  motor_stop,
   output logic                  error_out,
   output logic                  red_led
);
   // Oversample tick; both directions share it
   logic [15:0] os_cnt_r;
   logic        os_tick;
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
         os_cnt_r <= '0;
      else
         os_cnt_r <= os_tick ? '0 : os_cnt_r + 16'h1;
   end
   assign os_tick = (os_cnt_r == ucp_pkg::OS_DIV - 16'h1);

   // Receiver; rx_pin is only ever read
   ucp_pkg::ucp_state_e rx_st_r;
   logic [3:0] rx_os_r;
   logic [2:0] rx_bit_r;
   logic [7:0] rx_sh_r;
   logic       rx_push_r;
   logic [7:0] rx_data_r;
   logic       fe_r;
   logic       fifo_in_ready;
   logic       serial_on;
   assign serial_on = (control_mode == ucp_pkg::MODE_SERIAL);

   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rx_st_r   <= ucp_pkg::UCP_IDLE;
         rx_os_r   <= '0;
         rx_bit_r  <= '0;
         rx_sh_r   <= '0;
         rx_push_r <= 1'b0;
         rx_data_r <= '0;
         fe_r      <= 1'b0;
      end
      else
      begin
         rx_push_r <= 1'b0;
         fe_r      <= 1'b0;
         if (os_tick)
         begin
            case (rx_st_r)
               ucp_pkg::UCP_IDLE:
               begin
                  rx_os_r <= '0;
                  if (rx_pin == ucp_pkg::START_LVL && serial_on)
                     rx_st_r <= ucp_pkg::UCP_START;
               end
               ucp_pkg::UCP_START:
               begin
                  rx_os_r <= rx_os_r + 4'h1;
                  if (rx_os_r == ucp_pkg::OS_MID)
                  begin
                     rx_os_r  <= '0;
                     rx_bit_r <= '0;
                     // Glitch shorter than half a bit is not a start
                     rx_st_r  <= (rx_pin == ucp_pkg::START_LVL) ? ucp_pkg::UCP_DATA
                                                                : ucp_pkg::UCP_IDLE;
                  end
               end
               ucp_pkg::UCP_DATA:
               begin
                  rx_os_r <= rx_os_r + 4'h1;
                  if (rx_os_r == ucp_pkg::OS_LAST)
                  begin
                     rx_sh_r  <= {rx_pin, rx_sh_r[7:1]};
                     rx_bit_r <= rx_bit_r + 3'h1;
                     if (rx_bit_r == ucp_pkg::BIT_LAST)
                        rx_st_r <= ucp_pkg::UCP_STOP;
                  end
               end
               ucp_pkg::UCP_STOP:
               begin
                  rx_os_r <= rx_os_r + 4'h1;
                  if (rx_os_r == ucp_pkg::OS_LAST)
                  begin
                     rx_st_r <= ucp_pkg::UCP_IDLE;
                     if (rx_pin == ucp_pkg::LINE_IDLE)
                     begin
                        // Full FIFO drops the byte; host must pace its commands
                        rx_push_r <= fifo_in_ready;
                        rx_data_r <= rx_sh_r;
                     end
                     else
                        fe_r <= 1'b1;
                  end
               end
               default: rx_st_r <= ucp_pkg::UCP_IDLE;
            endcase
         end
      end
   end
   assign frame_error = fe_r;

   // Every byte begun in serial mode with a good stop bit that finds room in the FIFO goes to the command decoder regardless of address
   logic [7:0] fifo_out;
   ucp_fifo #(
      .WIDTH (ucp_pkg::DATA_W),
      .DEPTH (ucp_pkg::FIFO_DEPTH)
   ) u_rx_fifo (
      .clock     (clock),
      .arst_n    (arst_n),
      .in_data   (rx_data_r),
      .in_valid  (rx_push_r),
      .in_ready  (fifo_in_ready),
      .out_data  (fifo_out),
      .out_valid (cmd_valid),
      .out_ready (cmd_ready)
   );
   assign cmd_byte.data = fifo_out;

   // Transmitter: 10-bit frame shifted out LSB first
   logic [9:0] tx_sh_r;
   logic [3:0] tx_bits_r;
   logic [3:0] tx_os_r;
   assign reply_ready = (tx_bits_r == '0);
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         tx_sh_r   <= '1;
         tx_bits_r <= '0;
         tx_os_r   <= '0;
      end
      else if (reply_valid && reply_ready)
      begin
         tx_sh_r   <= {ucp_pkg::LINE_IDLE, reply_byte.data, ucp_pkg::START_LVL};
         tx_bits_r <= 4'ha;
         tx_os_r   <= '0;
      end
      else if (os_tick && tx_bits_r != '0)
      begin
         tx_os_r <= tx_os_r + 4'h1;
         if (tx_os_r == ucp_pkg::OS_LAST)
         begin
            tx_sh_r   <= {ucp_pkg::LINE_IDLE, tx_sh_r[9:1]};
            tx_bits_r <= tx_bits_r - 4'h1;
         end
      end
   end
   assign tx_pin = tx_sh_r[0];

   // Command timeout; a kick within the limit keeps motion going
   logic [31:0] to_cnt_r;
   logic        to_err_r;
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         to_cnt_r <= '0;
         to_err_r <= 1'b0;
      end
      else if (!timeout_enable || timeout_kick)
      begin
         to_cnt_r <= '0;
         to_err_r <= 1'b0;
      end
      else if (to_cnt_r == 32'(TIMEOUT_CYCLES - 1))
         to_err_r <= 1'b1;
      else
         to_cnt_r <= to_cnt_r + 32'h1;
   end
   assign timeout_error = to_err_r;
   assign motor_stop    = to_err_r || other_error;
   assign error_out     = motor_stop;
   assign red_led       = motor_stop;
endmodule

// File: testbench/ucp_port_checker.sv
// Concurrent checks on the serial command port pins
`timescale 1ns/10ps
module ucp_port_checker (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic tx_pin,
   input wire logic timeout_enable,
   input wire logic timeout_kick,
   input wire logic other_error,
   input wire logic reply_valid,
   input wire logic reply_ready,
   input wire logic frame_error,
   input wire logic timeout_error,
   input wire logic motor_stop,
   input wire logic error_out,
   input wire logic red_led
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!arst_n);
   sequence s_accept;
      reply_valid && reply_ready;
   endsequence
   sequence s_start_bit;
      !tx_pin && !reply_ready;
   endsequence
   chk_idle_high: assert property (reply_ready |-> tx_pin)
      else $error("tx line low while transmitter idle");
   chk_start_low: assert property (s_accept |=> s_start_bit [*8])
      else $error("no start bit after accept");
   chk_stop_high: assert property ($rose(reply_ready) |-> $past(tx_pin, 8))
      else $error("stop bit too short");
   chk_err_out: assert property (error_out == (timeout_error || other_error))
      else $error("error output mismatch");
   chk_red_led: assert property (red_led == error_out)
      else $error("red indicator mismatch");
   chk_motor_stop: assert property (motor_stop == error_out)
      else $error("motor stop mismatch");
   chk_kick_clear: assert property (timeout_kick |=> !timeout_error)
      else $error("kick did not clear timeout");
   chk_off_clear: assert property (!timeout_enable |=> !timeout_error)
      else $error("timeout raised while disabled");
   chk_rise_cause: assert property ($rose(timeout_error) |-> $past(timeout_enable))
      else $error("timeout rose without enable");
   chk_ferr_pulse: assert property (frame_error |=> !frame_error)
      else $error("frame error longer than one cycle");
endmodule

bind ucp_port ucp_port_checker chk (.clock(clock), .arst_n(arst_n), .tx_pin(tx_pin),
   .timeout_enable(timeout_enable), .timeout_kick(timeout_kick), .other_error(other_error),
   .reply_valid(reply_valid), .reply_ready(reply_ready), .frame_error(frame_error),
   .timeout_error(timeout_error), .motor_stop(motor_stop), .error_out(error_out),
   .red_led(red_led));

// File: testbench/ucp_host_model.sv
// Serial host model: sends 8-N-1 frames and collects reply bytes
`timescale 1ns/10ps
module ucp_host_model #(
   parameter real BIT_NS = 104166.7
) (
   output logic      host_tx,
   input  wire logic host_rx
);
   logic [7:0] got_q[$];
   logic [7:0] sh;
   initial host_tx = 1'b1;
   // Own time base, deliberately a little off the device's bit period
   task automatic send(input logic [7:0] d, input logic stop);
      host_tx = 1'b0;
      #(BIT_NS);
      for (int i = 0; i < 8; i++)
      begin
         host_tx = d[i];
         #(BIT_NS);
      end
      host_tx = stop;
      #(BIT_NS);
      host_tx = 1'b1;
      #(BIT_NS);
   endtask
   // One bit time low, then long enough idle for a wrongly accepted frame to surface
   task automatic pulse_low();
      host_tx = 1'b0;
      #(BIT_NS);
      host_tx = 1'b1;
      #(BIT_NS * 10);
   endtask
   always @(negedge host_rx)
   begin
      #(BIT_NS * 1.5);
      for (int i = 0; i < 8; i++)
      begin
         sh[i] = host_rx;
         #(BIT_NS);
      end
      if (host_rx === 1'b1)
         got_q.push_back(sh);
   end
endmodule

// File: testbench/tb.sv
// Testbench for the serial command port
`timescale 1ns/10ps
module tb;
   localparam int TO = 1000;
   logic               clock = 1'b0;
   logic               arst_n = 1'b0;
   logic               rx_pin, tx_pin, cmd_valid, frame_error, reply_ready;
   logic [1:0]         control_mode = 2'h0;
   logic               timeout_enable = 1'b0, timeout_kick = 1'b0, other_error = 1'b0;
   logic               cmd_ready = 1'b0, reply_valid = 1'b0;
   ucp_pkg::ucp_byte_s cmd_byte, reply_byte = '0;
   logic               timeout_error, motor_stop, error_out, red_led;
   int                 fails = 0, samples_checked = 0, ferr_seen = 0;
   logic [31:0]        seed = 32'h7de53494;
   logic [7:0]         rx_exp[$];
   logic [7:0]         d;
   ucp_port #(.TIMEOUT_CYCLES(TO)) uut (.clock(clock), .arst_n(arst_n), .rx_pin(rx_pin),
      .tx_pin(tx_pin), .control_mode(control_mode), .timeout_enable(timeout_enable),
      .timeout_kick(timeout_kick), .other_error(other_error), .cmd_byte(cmd_byte),
      .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .frame_error(frame_error),
      .reply_byte(reply_byte), .reply_valid(reply_valid), .reply_ready(reply_ready),
      .timeout_error(timeout_error), .motor_stop(motor_stop), .error_out(error_out),
      .red_led(red_led));
   ucp_host_model host (.host_tx(rx_pin), .host_rx(tx_pin));
   always #10 clock = ~clock;
   function automatic logic [7:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[7:0];
   endfunction
   task check(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         fails++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task results;
      $display("fails=%0d samples_checked=%0d", fails, samples_checked);
      if (fails == 0 && samples_checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // Sampled mid-cycle so the pop edge is never raced
   always @(negedge clock)
      if (cmd_valid === 1'b1)
         check(cmd_byte.data, rx_exp.size() ? rx_exp.pop_front() : 8'hxx);
   always @(negedge clock)
      if (frame_error === 1'b1)
         ferr_seen++;
   initial
   begin
      repeat (200000) @(posedge clock);
      fails++;
      results();
   end
   initial
   begin
      repeat (6) @(posedge clock);
      #1 arst_n = 1'b1;
      cmd_ready = 1'b1;
      timeout_enable = 1'b1;
      check(8'(tx_pin), 8'h1);
      repeat (TO - 10) @(posedge clock);
      #1 check(8'(timeout_error), 8'h0);
      repeat (20) @(posedge clock);
      #1 check({4'h0, timeout_error, motor_stop, error_out, red_led}, 8'h0f);
      #1 timeout_kick = 1'b1;
      @(posedge clock);
      #1 timeout_kick = 1'b0;
      check(8'(error_out), 8'h0);
      timeout_enable = 1'b0;
      other_error = 1'b1;
      @(posedge clock);
      #1 check({5'h0, motor_stop, error_out, red_led}, 8'h07);
      other_error = 1'b0;
      for (int i = 0; i < 10 && reply_ready !== 1'b1; i++)
         @(posedge clock);
      check(8'(reply_ready), 8'h1);
      reply_byte.data = xs();
      reply_valid = 1'b1;
      @(posedge clock);
      #1 reply_valid = 1'b0;
      d = xs();
      rx_exp.push_back(d);
      host.send(d, 1'b1);
      repeat (200) @(posedge clock);
      check(host.got_q.size() ? host.got_q.pop_front() : 8'hxx, reply_byte.data);
      check(8'(rx_exp.size()), 8'h0);
      host.send(xs(), 1'b0);
      repeat (200) @(posedge clock);
      check(8'(ferr_seen), 8'h1);
      // Outside the serial mode a start edge must be ignored entirely
      #1 control_mode = 2'h1;
      host.pulse_low();
      check(8'(ferr_seen), 8'h1);
      check(8'(cmd_valid), 8'h0);
      control_mode = 2'h0;
      check(8'(tx_pin), 8'h1);
      results();
   end
endmodule
